/* bench/lkc_cmd_engine_checker.sv */
// Port-level assertions for the command engine.
// Assumes binding onto lkc_cmd_engine; a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "lkc_map.svh"
module lkc_cmd_engine_checker (
    input wire logic                    core_clk,
    input wire logic                    resetn,
    input wire logic                    cmdValid,
    input wire logic                    cmdReady,
    input wire logic [9:0]              commandCode,
    input wire logic [15:0]             connHandle,
    input wire logic [7:0]              repeatClass,
    input wire logic [7:0]              scanMode,
    input wire logic [15:0]             clockOffset,
    input wire logic [`LKC_MASK_W-1:0]  eventMask,
    input wire logic                    isMaster,
    input wire logic                    encryptOn,
    input wire logic                    tempKeyInUse,
    input wire logic                    lmDone,
    input wire logic [7:0]              lmStatus,
    input wire logic                    evtValid,
    input wire logic [7:0]              evtCode,
    input wire logic [7:0]              evtStatus,
    input wire logic                    lmStart,
    input wire logic [1:0]              lmOp,
    input wire logic [14:0]             lmOffset,
    input wire logic                    lmOffsetValid,
    input wire logic                    cryptRestart,
    input wire logic                    peerNotify
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Edge at which the idle engine takes a command
    logic take;
    assign take = cmdValid && cmdReady;

    status_first_a: assert property (take |-> ##2
        (eventMask[0] || evtValid && evtCode == `LKC_EV_STATUS)) else $error("status event late");
    no_generic_a: assert property (evtValid |-> evtCode inside {
        `LKC_EV_STATUS, `LKC_EV_KEY_NOTIFY, `LKC_EV_RENEW_DONE,
        `LKC_EV_KEYSEL_DONE, `LKC_EV_NAME_DONE}) else $error("stray event code");
    bad_handle_a: assert property (take && commandCode == `LKC_CODE_RENEW
        && connHandle[11:0] > `LKC_HANDLE_MAX |-> ##2 !lmStart) else $error("reserved handle run");
    bad_scan_a: assert property (take && commandCode == `LKC_CODE_NAME
        && (repeatClass > `LKC_REP_MAX || scanMode > `LKC_SCAN_MAX) |-> ##2 !lmStart)
        else $error("reserved scan run");
    offset_pass_a: assert property (lmStart && lmOp == 2'h2 |->
        lmOffset == clockOffset[14:0] && lmOffsetValid == clockOffset[15]) else $error("offset bad");
    renew_seq_a: assert property (lmDone && lmOp == 2'h0 && lmStatus == 8'h00 |-> ##2
        peerNotify && (eventMask[1] || evtValid && evtCode == `LKC_EV_KEY_NOTIFY) ##1
        (eventMask[2] || evtValid && evtCode == `LKC_EV_RENEW_DONE)) else $error("renew events");
    crypt_restart_a: assert property (evtValid && evtCode == `LKC_EV_RENEW_DONE &&
        evtStatus == 8'h00 && isMaster && encryptOn && tempKeyInUse |=> cryptRestart)
        else $error("no encryption restart");
    name_done_a: assert property (lmDone && lmOp == 2'h2 |-> ##2
        (eventMask[4] || evtValid && evtCode == `LKC_EV_NAME_DONE)) else $error("name done late");
endmodule : lkc_cmd_engine_checker

bind lkc_cmd_engine lkc_cmd_engine_checker chkI (
    .core_clk(core_clk), .resetn(resetn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .commandCode(commandCode), .connHandle(connHandle),
    .repeatClass(repeatClass), .scanMode(scanMode), .clockOffset(clockOffset),
    .eventMask(eventMask), .isMaster(isMaster), .encryptOn(encryptOn),
    .tempKeyInUse(tempKeyInUse), .lmDone(lmDone), .lmStatus(lmStatus),
    .evtValid(evtValid), .evtCode(evtCode), .evtStatus(evtStatus),
    .lmStart(lmStart), .lmOp(lmOp), .lmOffset(lmOffset),
    .lmOffsetValid(lmOffsetValid), .cryptRestart(cryptRestart),
    .peerNotify(peerNotify));
`default_nettype wire

/* bench/lkc_cmd_engine_tb_top.sv */
// Self-checking bench for the link key and remote name engine.
// Assumes lkc_lm_model answers every link manager start.
`timescale 1ns/1ps
`default_nettype none
`include "lkc_map.svh"
module lkc_cmd_engine_tb_top;
    logic core_clk, resetn, cmdValid, isMaster, encryptOn, tempKeyInUse;
    logic connExists, lmStart, lmDone, peerRenewed, cmdReady, evtValid;
    logic lmTempLink, lmOffsetValid, lmKeyTemp, cryptRestart, peerNotify;
    logic [9:0]  commandCode, evtOpcode;
    logic [15:0] connHandle, clockOffset;
    logic [7:0]  keyFlag, repeatClass, scanMode, lmStatus, evtCode;
    logic [7:0]  evtStatus, lmRepeat, lmScan, replyDelay;
    logic [47:0] device_address, lmAddress;
    logic [11:0] slaveHandle, masterHandle, evtHandle, seenHandle;
    logic [14:0] lmOffset;
    logic [1:0]  lmOp;
    logic [`LKC_MASK_W-1:0] eventMask;
    int nErrors, checkCount, starts, events;

    lkc_cmd_engine uut (.core_clk(core_clk), .resetn(resetn),
        .cmdValid(cmdValid), .commandCode(commandCode), .connHandle(connHandle),
        .keyFlag(keyFlag), .device_address(device_address),
        .repeatClass(repeatClass), .scanMode(scanMode), .clockOffset(clockOffset),
        .eventMask(eventMask), .isMaster(isMaster), .encryptOn(encryptOn),
        .tempKeyInUse(tempKeyInUse), .connExists(connExists),
        .slaveHandle(slaveHandle), .masterHandle(masterHandle), .lmDone(lmDone),
        .lmStatus(lmStatus), .peerRenewed(peerRenewed), .cmdReady(cmdReady),
        .evtValid(evtValid), .evtCode(evtCode), .evtStatus(evtStatus),
        .evtHandle(evtHandle), .evtOpcode(evtOpcode), .lmStart(lmStart),
        .lmOp(lmOp), .lmTempLink(lmTempLink), .lmAddress(lmAddress),
        .lmRepeat(lmRepeat), .lmScan(lmScan), .lmOffset(lmOffset),
        .lmOffsetValid(lmOffsetValid), .lmKeyTemp(lmKeyTemp),
        .cryptRestart(cryptRestart), .peerNotify(peerNotify));
    lkc_lm_model lm (.core_clk(core_clk), .resetn(resetn), .lmStart(lmStart),
        .lmOp(lmOp), .replyStatus(8'h00), .replyDelay(replyDelay),
        .lmDone(lmDone), .lmStatus(lmStatus), .peerRenewed(peerRenewed));

    // Free-running 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Counts link starts and events for the no-activity checks
    always @(posedge core_clk) begin
        starts += (lmStart === 1'b1);
        events += (evtValid === 1'b1);
    end

    task automatic finalReport;
        if (nErrors == 0 && checkCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finalReport
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bounded wait until the engine reports idle
    task automatic waitIdle;
        int i;
        for (i = 0; i < 200 && cmdReady !== 1'b1; i++) @(negedge core_clk);
        if (i == 200) begin
            nErrors++;
            finalReport();
        end
    endtask : waitIdle
    // Raise cmdValid for one edge once the engine is idle
    task automatic send(input logic [9:0] code);
        commandCode = code;
        waitIdle();
        cmdValid = 1'b1;
        @(negedge core_clk);
        cmdValid = 1'b0;
    endtask : send
    // Wait, bounded, for the next event pulse and judge it
    task automatic evt(input logic [7:0] code, input logic [7:0] st);
        int i;
        for (i = 0; i < 300 && evtValid !== 1'b1; i++) @(negedge core_clk);
        if (i == 300) begin
            nErrors++;
            finalReport();
        end
        chk(evtCode, code);
        chk(evtStatus, st);
        // Handle only stands during the event cycle
        seenHandle = evtHandle;
        @(negedge core_clk);
    endtask : evt

    task automatic runRenew;
        {isMaster, encryptOn, tempKeyInUse} = 3'h7;
        connHandle = 16'hFEFF; // Data link handle at the limit
        send(`LKC_CODE_RENEW);
        evt(`LKC_EV_STATUS, `LKC_ST_OK);
        chk(evtOpcode, `LKC_CODE_RENEW);
        evt(`LKC_EV_KEY_NOTIFY, `LKC_ST_OK);
        evt(`LKC_EV_RENEW_DONE, `LKC_ST_OK);
        chk(cryptRestart, 1'b1);
    endtask : runRenew
    task automatic runBad;
        logic [9:0] codes [4] = '{10'h015, 10'h019, 10'h019, 10'h016};
        for (int i = 0; i < 4; i++) begin
            int s0 = starts;
            connHandle = 16'h0F00;
            repeatClass = (i == 1) ? 8'h03 : 8'h00;
            scanMode = (i == 2) ? 8'h04 : 8'h00;
            send(codes[i]);
            evt(`LKC_EV_STATUS, (i == 3) ? `LKC_ST_UNKNOWN_CMD : `LKC_ST_BAD_PARAM);
            chk(starts - s0, 0);
        end
    endtask : runBad
    task automatic runKeysel;
        for (int i = 0; i < 2; i++) begin
            keyFlag = i[7:0];
            isMaster = i[0];
            send(`LKC_CODE_KEYSEL);
            evt(`LKC_EV_STATUS, `LKC_ST_OK);
            chk(lmKeyTemp, i[0]);
            evt(`LKC_EV_KEYSEL_DONE, `LKC_ST_OK);
            chk(seenHandle, i[0] ? slaveHandle : masterHandle);
        end
    endtask : runKeysel
    task automatic runName;
        for (int i = 0; i < 4; i++) begin
            repeatClass = 8'(i % 3);
            scanMode = i[7:0];
            connExists = i[0];
            clockOffset = {i[1], 15'h2AB5 ^ i[14:0]};
            device_address = 48'hC0FFEE123456 + i;
            replyDelay = 8'(i * 7);
            send(`LKC_CODE_NAME);
            evt(`LKC_EV_STATUS, `LKC_ST_OK);
            chk(lmAddress, device_address);
            chk({lmRepeat, lmScan}, {repeatClass, scanMode});
            chk({lmOffsetValid, lmOffset}, clockOffset);
            chk(lmTempLink, !connExists);
            evt(`LKC_EV_NAME_DONE, `LKC_ST_OK);
        end
    endtask : runName
    task automatic runMask;
        int s0 = starts;
        int e0 = events;
        eventMask = '1;
        connHandle = 16'h0001; // Legal handle so all three run
        send(`LKC_CODE_RENEW);
        send(`LKC_CODE_NAME);
        send(`LKC_CODE_KEYSEL);
        waitIdle();
        chk(events - e0, 0);
        chk(starts - s0, 3);
        eventMask = '0;
    endtask : runMask

    initial begin
        {cmdValid, isMaster, encryptOn, tempKeyInUse, connExists} = '0;
        {commandCode, connHandle, clockOffset, keyFlag} = '0;
        {repeatClass, scanMode, device_address, eventMask} = '0;
        slaveHandle = 12'h123;
        masterHandle = 12'h456;
        replyDelay = 8'h03;
        resetn = 1'b0;
        repeat (20) @(negedge core_clk);
        resetn = 1'b1;
        runRenew();
        runBad();
        runKeysel();
        runName();
        runMask();
        send(`LKC_CODE_KEYSEL);
        evt(`LKC_EV_STATUS, `LKC_ST_OK);
        finalReport();
    end
endmodule : lkc_cmd_engine_tb_top
`default_nettype wire

/* bench/lkc_lm_model.sv */
// Behavioural link manager facing the engine's lm* ports.
// Assumes one exchange at a time, started by an lmStart pulse.
`timescale 1ns/1ps
`default_nettype none
module lkc_lm_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       lmStart,
    input  wire logic [1:0] lmOp,
    input  wire logic [7:0] replyStatus,
    input  wire logic [7:0] replyDelay,
    output logic            lmDone,
    output logic [7:0]      lmStatus,
    output logic            peerRenewed
);
    logic [7:0] count;
    logic       busy;
    // Answers after a set delay; status toggles as junk between answers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy        <= 1'b0;
            count       <= 8'h00;
            lmDone      <= 1'b0;
            lmStatus    <= 8'hA5;
            peerRenewed <= 1'b0;
        end else begin
            lmDone      <= 1'b0;
            peerRenewed <= 1'b0;
            lmStatus    <= ~lmStatus;
            if (lmStart) begin
                busy  <= 1'b1;
                count <= replyDelay;
            end else if (busy && count == 8'h00) begin
                busy        <= 1'b0;
                lmDone      <= 1'b1;
                lmStatus    <= replyStatus;
                peerRenewed <= (lmOp == 2'h0);
            end else if (busy) begin
                count <= count - 8'h01;
            end
        end
    end
endmodule : lkc_lm_model
`default_nettype wire

/* core/lkc_cmd_engine.sv */
// Command interpreter for key renewal, key selection and remote name.
// Assumes a link manager that takes lmStart and pulses lmDone once.
//
// Functional notes
// - Renew key command code 0x0015 accepted
// - Handle low 12 bits, above 0xEFF reserved
// - Command status event precedes completion
// - Renewal gives notify and completion events
// - No generic command complete event ever
// - Master restarts encryption with temporary key
// - Key select code 0x0017, flag 0 or 1
// - Key select completion carries command status
// - Completion handle depends on master role
// - Name command code 0x0019, ordered fields
// - Repetition class above 0x02 reserved
// - Scan mode above 0x03 reserved
// - Offset bit 15 marks offset valid
// - Temporary link when no connection exists
// - Name completion after link exchange
`timescale 1ns/1ps
`default_nettype none
`include "lkc_map.svh"
module lkc_cmd_engine (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic                  cmdValid,
    input  wire logic [9:0]            commandCode,
    input  wire logic [15:0]           connHandle,
    input  wire logic [7:0]            keyFlag,
    input  wire logic [47:0]           device_address,
    input  wire logic [7:0]            repeatClass,
    input  wire logic [7:0]            scanMode,
    input  wire logic [15:0]           clockOffset,
    input  wire logic [`LKC_MASK_W-1:0] eventMask,
    input  wire logic                  isMaster,
    input  wire logic                  encryptOn,
    input  wire logic                  tempKeyInUse,
    input  wire logic                  connExists,
    input  wire logic [11:0]           slaveHandle,
    input  wire logic [11:0]           masterHandle,
    input  wire logic                  lmDone,
    input  wire logic [7:0]            lmStatus,
    input  wire logic                  peerRenewed,
    output logic                       cmdReady,
    output logic                       evtValid,
    output logic [7:0]                 evtCode,
    output logic [7:0]                 evtStatus,
    output logic [11:0]                evtHandle,
    output logic [9:0]                 evtOpcode,
    output logic                       lmStart,
    output logic [1:0]                 lmOp,
    output logic                       lmTempLink,
    output logic [47:0]                lmAddress,
    output logic [7:0]                 lmRepeat,
    output logic [7:0]                 lmScan,
    output logic [14:0]                lmOffset,
    output logic                       lmOffsetValid,
    output logic                       lmKeyTemp,
    output logic                       cryptRestart,
    output logic                       peerNotify
);
    lkc_pkg::lkc_state_e state;
    lkc_pkg::lkc_op_e    op;
    logic                known;
    logic                paramOk;
    logic [9:0]          code;
    logic [11:0]         handle;
    logic                keySel;
    logic [7:0]          doneStatus;
    logic                takenOk;
    logic                takenKnown;

    lkc_param_check uCheck (
        .commandCode (commandCode),
        .connHandle  (connHandle),
        .keyFlag     (keyFlag),
        .repeatClass (repeatClass),
        .scanMode    (scanMode),
        .known       (known),
        .paramOk     (paramOk)
    );

    // Which operation a code selects
    function automatic lkc_pkg::lkc_op_e decode_op(input logic [9:0] c);
        case (c)
            `LKC_CODE_RENEW:  decode_op = lkc_pkg::OP_RENEW;
            `LKC_CODE_KEYSEL: decode_op = lkc_pkg::OP_KEYSEL;
            `LKC_CODE_NAME:   decode_op = lkc_pkg::OP_NAME;
            default:          decode_op = lkc_pkg::OP_NONE;
        endcase
    endfunction : decode_op

    // Deliver an event unless its mask bit is set
    function automatic logic unmasked(input logic [`LKC_MASK_W-1:0] m,
                                      input logic [2:0] idx);
        unmasked = ~m[idx];
    endfunction : unmasked

    // Sequencer: status, link work, notify, completion
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= lkc_pkg::ST_IDLE;
        end else begin
            case (state)
                lkc_pkg::ST_IDLE:
                    if (cmdValid) state <= lkc_pkg::ST_STATUS;
                lkc_pkg::ST_STATUS:
                    state <= takenOk ? lkc_pkg::ST_WAIT : lkc_pkg::ST_IDLE;
                lkc_pkg::ST_WAIT:
                    if (lmDone) begin
                        if (op == lkc_pkg::OP_RENEW && lmStatus == `LKC_ST_OK)
                            state <= lkc_pkg::ST_NOTIFY;
                        else
                            state <= lkc_pkg::ST_DONE;
                    end
                lkc_pkg::ST_NOTIFY: state <= lkc_pkg::ST_DONE;
                lkc_pkg::ST_DONE: begin
                    // Restart only after renewal under temporary key
                    if (op == lkc_pkg::OP_RENEW && isMaster && encryptOn
                        && tempKeyInUse && doneStatus == `LKC_ST_OK)
                        state <= lkc_pkg::ST_CRYPT;
                    else
                        state <= lkc_pkg::ST_IDLE;
                end
                lkc_pkg::ST_CRYPT: state <= lkc_pkg::ST_IDLE;
                default: state <= lkc_pkg::ST_IDLE;
            endcase
        end
    end

    // Capture the command when taken
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            op            <= lkc_pkg::OP_NONE;
            code          <= 10'h000;
            handle        <= 12'h000;
            keySel        <= 1'b0;
            lmAddress     <= 48'h0;
            lmRepeat      <= 8'h00;
            lmScan        <= 8'h00;
            lmOffset      <= 15'h0000;
            lmOffsetValid <= 1'b0;
            takenOk       <= 1'b0;
            takenKnown    <= 1'b0;
        end else if (state == lkc_pkg::ST_IDLE && cmdValid) begin
            // Verdict frozen at take; host may change fields afterwards
            takenOk       <= paramOk;
            takenKnown    <= known;
            op            <= decode_op(commandCode);
            code          <= commandCode;
            handle        <= connHandle[11:0];
            keySel        <= keyFlag[0];
            lmAddress     <= device_address;
            lmRepeat      <= repeatClass;
            lmScan        <= scanMode;
            lmOffset      <= clockOffset[14:0];
            // Flag travels with the raw offset; user must honour it
            lmOffsetValid <= clockOffset[`LKC_OFS_VALID_BIT];
        end
    end

    // Completion status from the link manager
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            doneStatus <= `LKC_ST_OK;
        else if (state == lkc_pkg::ST_WAIT && lmDone)
            doneStatus <= lmStatus;
    end

    // Link manager request, only for legal commands
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lmStart    <= 1'b0;
            lmOp       <= 2'h0;
            lmTempLink <= 1'b0;
            lmKeyTemp  <= 1'b0;
        end else begin
            lmStart <= (state == lkc_pkg::ST_STATUS) && takenOk;
            if (state == lkc_pkg::ST_STATUS) begin
                lmOp       <= op;
                lmTempLink <= (op == lkc_pkg::OP_NAME) && !connExists;
                lmKeyTemp  <= keySel;
            end
        end
    end

    // Side effects toward the radio and the peer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cryptRestart <= 1'b0;
            peerNotify   <= 1'b0;
        end else begin
            cryptRestart <= (state == lkc_pkg::ST_CRYPT);
            // Peer raises its own notify once its key is new
            peerNotify   <= peerRenewed || (state == lkc_pkg::ST_NOTIFY);
        end
    end

    // Event generator; no generic completion code exists here
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            evtValid  <= 1'b0;
            evtCode   <= 8'h00;
            evtStatus <= 8'h00;
            evtHandle <= 12'h000;
            evtOpcode <= 10'h000;
        end else begin
            evtValid  <= 1'b0;
            evtOpcode <= code;
            evtHandle <= handle;
            case (state)
                lkc_pkg::ST_STATUS: begin
                    evtValid  <= unmasked(eventMask, `LKC_MASK_STATUS);
                    evtCode   <= `LKC_EV_STATUS;
                    evtStatus <= takenOk ? `LKC_ST_OK
                               : (takenKnown ? `LKC_ST_BAD_PARAM
                                             : `LKC_ST_UNKNOWN_CMD);
                end
                lkc_pkg::ST_NOTIFY: begin
                    evtValid  <= unmasked(eventMask, `LKC_MASK_NOTIFY);
                    evtCode   <= `LKC_EV_KEY_NOTIFY;
                    evtStatus <= `LKC_ST_OK;
                end
                lkc_pkg::ST_DONE: begin
                    evtStatus <= doneStatus;
                    case (op)
                        lkc_pkg::OP_RENEW: begin
                            evtValid <= unmasked(eventMask, `LKC_MASK_RENEW);
                            evtCode  <= `LKC_EV_RENEW_DONE;
                        end
                        lkc_pkg::OP_KEYSEL: begin
                            evtValid  <= unmasked(eventMask, `LKC_MASK_KEYSEL);
                            evtCode   <= `LKC_EV_KEYSEL_DONE;
                            evtHandle <= isMaster ? slaveHandle
                                                  : masterHandle;
                        end
                        default: begin
                            evtValid <= unmasked(eventMask, `LKC_MASK_NAME);
                            evtCode  <= `LKC_EV_NAME_DONE;
                        end
                    endcase
                end
                default: evtCode <= evtCode;
            endcase
        end
    end

    // One command at a time
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            cmdReady <= 1'b0;
        else
            cmdReady <= (state == lkc_pkg::ST_IDLE) && !cmdValid;
    end
endmodule : lkc_cmd_engine
`default_nettype wire

/* core/lkc_map.svh */
// Constants for the link key and remote name command interpreter.
// Assumes inclusion by bare name from core/ sources.
`ifndef LKC_MAP_SVH
`define LKC_MAP_SVH

`define LKC_CODE_RENEW      10'h015
`define LKC_CODE_KEYSEL     10'h017
`define LKC_CODE_NAME       10'h019
`define LKC_HANDLE_MAX      12'hEFF
`define LKC_KEY_SEMI        8'h00
`define LKC_KEY_TEMP        8'h01
`define LKC_REP_MAX         8'h02
`define LKC_SCAN_MAX        8'h03
`define LKC_OFS_VALID_BIT   15
`define LKC_ST_OK           8'h00
`define LKC_ST_BAD_PARAM    8'h12
`define LKC_ST_UNKNOWN_CMD  8'h01
`define LKC_EV_STATUS       8'h0F
`define LKC_EV_KEY_NOTIFY   8'h15
`define LKC_EV_RENEW_DONE   8'h09
`define LKC_EV_KEYSEL_DONE  8'h0A
`define LKC_EV_NAME_DONE    8'h07
`define LKC_MASK_STATUS     3'd0
`define LKC_MASK_NOTIFY     3'd1
`define LKC_MASK_RENEW      3'd2
`define LKC_MASK_KEYSEL     3'd3
`define LKC_MASK_NAME       3'd4
`define LKC_MASK_W          5

`endif

/* core/lkc_param_check.sv */
// Parameter legality check for the three commands.
// Assumes command fields are stable while cmdValid is high.
`timescale 1ns/1ps
`default_nettype none
`include "lkc_map.svh"
module lkc_param_check (
    input  wire logic [9:0]  commandCode,
    input  wire logic [15:0] connHandle,
    input  wire logic [7:0]  keyFlag,
    input  wire logic [7:0]  repeatClass,
    input  wire logic [7:0]  scanMode,
    output logic             known,
    output logic             paramOk
);
    // Unknown codes are reported, never acted on
    always_comb begin
        known   = 1'b1;
        paramOk = 1'b1;
        case (commandCode)
            `LKC_CODE_RENEW:  paramOk = connHandle[11:0] <= `LKC_HANDLE_MAX;
            `LKC_CODE_KEYSEL: paramOk = keyFlag <= `LKC_KEY_TEMP;
            `LKC_CODE_NAME:   paramOk = (repeatClass <= `LKC_REP_MAX)
                                     && (scanMode <= `LKC_SCAN_MAX);
            default: begin
                known   = 1'b0;
                paramOk = 1'b0;
            end
        endcase
    end
endmodule : lkc_param_check
`default_nettype wire

/* core/lkc_pkg.sv */
// Types for the link key and remote name command interpreter.
// Assumes lkc_map.svh supplies all numeric constants.
package lkc_pkg;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_STATUS = 6'b000010,
        ST_WAIT   = 6'b000100,
        ST_NOTIFY = 6'b001000,
        ST_DONE   = 6'b010000,
        ST_CRYPT  = 6'b100000
    } lkc_state_e;

    typedef enum logic [1:0] {
        OP_RENEW  = 2'h0,
        OP_KEYSEL = 2'h1,
        OP_NAME   = 2'h2,
        OP_NONE   = 2'h3
    } lkc_op_e;
endpackage : lkc_pkg
